// [hdl/spffe_top.sv]
`timescale 1ns/1ps
module spffe_top #(
   parameter logic [7:0] OPC_REWRITE = 8'h01,
   parameter logic [7:0] OPC_BURN = 8'h02,
   parameter logic [7:0] OPC_PAGE_CLEAR = 8'h03,
   parameter logic [7:0] OPC_SECTOR_CLEAR = 8'h04
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // serial pins
   input wire logic sclk_in,
   input wire logic cs_n_in,
   input wire logic mosi_in,
   input wire logic wp_n_in,
   input wire logic hw_rst_n_in,
   output logic miso_out,
   output logic miso_oe_out,
   // received byte stream
   output logic rx_valid_out,
   input wire logic rx_ready_in,
   output spffe_pkg::spffe_rx_t rx_out,
   output logic overrun_out,
   // transmit bytes from the core
   input wire logic tx_enable_in,
   input wire logic tx_valid_in,
   input wire logic [7:0] tx_data_in,
   output logic tx_ready_out,
   // internal operation control
   input wire logic busy_in,
   output logic op_start_out,
   output spffe_pkg::spffe_op_t op_out,
   output logic op_refused_out,
   output logic abort_out,
   // power state
   output logic standby_out,
   output logic active_out
);

   // pin synchronisers, stage 2 is the first one logic may read
   logic [spffe_pkg::SYNC_W-1:0] sclk_q, cs_q, hrst_q;
   logic [1:0] mosi_q, wp_q;

   spffe_pkg::spffe_state_t state, next_state;
   logic [2:0] bitcnt, next_bitcnt;
   logic [2:0] byte_idx, next_byte_idx;
   logic [8:0] data_cnt, next_data_cnt;
   logic [7:0] rx_sh, next_rx_sh;
   logic [6:0] tx_sh, next_tx_sh;
   logic bit_seen, next_bit_seen;
   localparam int ADDR_BITS = spffe_pkg::ADDR_W;
   logic [7:0] opcode, next_opcode;
   logic [ADDR_BITS-1:0] addr, next_addr;
   logic pend_valid, next_pend_valid;
   spffe_pkg::spffe_rx_t pend, next_pend;
   logic spare_valid, next_spare_valid;
   spffe_pkg::spffe_rx_t spare, next_spare;
   logic next_rx_valid;
   spffe_pkg::spffe_rx_t next_rx;
   logic next_miso, next_miso_oe, next_overrun, next_tx_ready;
   logic next_op_start, next_op_refused, next_abort;
   spffe_pkg::spffe_op_t next_op;
   logic next_standby, next_active;

   logic sclk_rise, sclk_fall, cs_rise, cs_fall, hrst_fall;

   assign sclk_rise = sclk_q[1] & ~sclk_q[2];
   assign sclk_fall = ~sclk_q[1] & sclk_q[2];
   assign cs_rise = cs_q[1] & ~cs_q[2];
   assign cs_fall = ~cs_q[1] & cs_q[2];
   assign hrst_fall = ~hrst_q[1] & hrst_q[2];

   // maps an opcode to an operation kind; known is low for any other code
   function automatic logic op_decode(input logic [7:0] code,
                                      output spffe_pkg::spffe_op_kind_t kind);
      kind = spffe_pkg::SPFFE_OP_REWRITE;
      op_decode = 1'b1;
      if (code == OPC_REWRITE) begin
         kind = spffe_pkg::SPFFE_OP_REWRITE;
      end else if (code == OPC_BURN) begin
         kind = spffe_pkg::SPFFE_OP_BURN;
      end else if (code == OPC_PAGE_CLEAR) begin
         kind = spffe_pkg::SPFFE_OP_PAGE_CLEAR;
      end else if (code == OPC_SECTOR_CLEAR) begin
         kind = spffe_pkg::SPFFE_OP_SECTOR_CLEAR;
      end else begin
         op_decode = 1'b0;
      end
   endfunction : op_decode

   // lowest 256 pages; a sector clear of sector 0 falls in them too
   function automatic logic in_prot_area(input logic [ADDR_BITS-1:0] a);
      in_prot_area = a[ADDR_BITS-1:8] < spffe_pkg::PROT_LIMIT;
   endfunction : in_prot_area

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sclk_q <= '0;
         cs_q <= '1;
         hrst_q <= '0;
         mosi_q <= '0;
         wp_q <= '0;
      end else begin
         sclk_q <= {sclk_q[1:0], sclk_in};
         cs_q <= {cs_q[1:0], cs_n_in};
         hrst_q <= {hrst_q[1:0], hw_rst_n_in};
         mosi_q <= {mosi_q[0], mosi_in};
         wp_q <= {wp_q[0], wp_n_in};
      end
   end

   always_comb begin
      spffe_pkg::spffe_op_kind_t kind;
      logic known;
      logic [7:0] byte_now;
      logic [7:0] tx_byte;
      kind = spffe_pkg::SPFFE_OP_REWRITE;
      known = 1'b0;
      byte_now = '0;
      tx_byte = spffe_pkg::IDLE_TX;
      next_state = state;
      next_bitcnt = bitcnt;
      next_byte_idx = byte_idx;
      next_data_cnt = data_cnt;
      next_rx_sh = rx_sh;
      next_tx_sh = tx_sh;
      next_bit_seen = bit_seen;
      next_opcode = opcode;
      next_addr = addr;
      next_pend_valid = pend_valid;
      next_pend = pend;
      next_spare_valid = spare_valid;
      next_spare = spare;
      next_rx_valid = rx_valid_out;
      next_rx = rx_out;
      next_miso = miso_out;
      next_overrun = 1'b0;
      next_tx_ready = 1'b0;
      next_op_start = 1'b0;
      next_op_refused = 1'b0;
      next_abort = 1'b0;
      next_op = op_out;

      // two-entry buffer: pop the head, then move the pending byte in
      if (rx_valid_out && rx_ready_in) begin
         if (spare_valid) begin
            next_rx = spare;
            next_spare_valid = 1'b0;
         end else begin
            next_rx_valid = 1'b0;
         end
      end
      // a full buffer holds the byte in pend rather than dropping it
      if (pend_valid && !spare_valid) begin
         if (!next_rx_valid) begin
            next_rx = pend;
            next_rx_valid = 1'b1;
         end else begin
            next_spare = pend;
            next_spare_valid = 1'b1;
         end
         next_pend_valid = 1'b0;
      end

      if (!hrst_q[1]) begin
         next_state = spffe_pkg::SPFFE_ST_UNARMED;
         next_bitcnt = '0;
         next_byte_idx = '0;
         next_data_cnt = '0;
         next_bit_seen = 1'b0;
         next_abort = hrst_fall && busy_in;
      end else begin
         unique case (state)
            spffe_pkg::SPFFE_ST_UNARMED, spffe_pkg::SPFFE_ST_IDLE: begin
               // only a fresh select edge opens a frame, never a level
               if (cs_fall) begin
                  next_state = spffe_pkg::SPFFE_ST_FRAME;
                  next_bitcnt = '0;
                  next_byte_idx = '0;
                  next_data_cnt = '0;
                  next_bit_seen = 1'b0;
               end
            end
            spffe_pkg::SPFFE_ST_FRAME: begin
               if (cs_rise) begin
                  next_state = spffe_pkg::SPFFE_ST_IDLE;
                  known = op_decode(opcode, kind);
                  if (known && byte_idx == spffe_pkg::IDX_DATA) begin
                     next_op.kind = kind;
                     next_op.addr = addr;
                     next_op.nbytes = data_cnt;
                     if ((kind == spffe_pkg::SPFFE_OP_REWRITE ||
                          kind == spffe_pkg::SPFFE_OP_BURN) && data_cnt == '0) begin
                        next_op_refused = 1'b1;
                     end else if (busy_in) begin
                        next_op_refused = 1'b1;
                     end else if (!wp_q[1] && in_prot_area(addr)) begin
                        next_op_refused = 1'b1;
                     end else begin
                        next_op_start = 1'b1;
                     end
                  end
               end else begin
                  if (sclk_rise) begin
                     byte_now = {rx_sh[6:0], mosi_q[1]};
                     next_rx_sh = byte_now;
                     next_bit_seen = 1'b1;
                     next_bitcnt = 3'(bitcnt + 3'h1);
                     if (bitcnt == spffe_pkg::BIT_LAST) begin
                        if (byte_idx == '0) begin
                           next_opcode = byte_now;
                        end else if (byte_idx != spffe_pkg::IDX_DATA) begin
                           next_addr = ADDR_BITS'({addr, byte_now});
                        end
                        if (byte_idx != spffe_pkg::IDX_DATA) begin
                           next_byte_idx = 3'(byte_idx + 3'h1);
                        end
                        // bytes past a full page are not passed on
                        if (byte_idx != spffe_pkg::IDX_DATA ||
                            data_cnt != spffe_pkg::MAX_DATA) begin
                           if (byte_idx == spffe_pkg::IDX_DATA) begin
                              next_data_cnt = 9'(data_cnt + 9'h1);
                           end
                           if (next_pend_valid) begin
                              next_overrun = 1'b1;
                           end else begin
                              next_pend_valid = 1'b1;
                              next_pend.data = byte_now;
                              if (byte_idx == '0) begin
                                 next_pend.tag = spffe_pkg::SPFFE_TAG_OPCODE;
                              end else if (byte_idx == spffe_pkg::IDX_DATA) begin
                                 next_pend.tag = spffe_pkg::SPFFE_TAG_DATA;
                              end else begin
                                 next_pend.tag = spffe_pkg::SPFFE_TAG_ADDR;
                              end
                           end
                        end
                     end
                  end
                  // mode 3 opens with a falling edge before any bit; skip it
                  if (sclk_fall && bit_seen) begin
                     if (bitcnt == '0) begin
                        next_tx_ready = 1'b1;
                        if (tx_valid_in) begin
                           tx_byte = tx_data_in;
                        end
                        next_miso = tx_byte[7];
                        next_tx_sh = tx_byte[6:0];
                     end else begin
                        next_miso = tx_sh[6];
                        next_tx_sh = {tx_sh[5:0], 1'b1};
                     end
                  end
               end
            end
            default: begin
               next_state = spffe_pkg::SPFFE_ST_UNARMED;
            end
         endcase
      end

      next_miso_oe = hrst_q[1] && !cs_q[1] && tx_enable_in &&
                     next_state == spffe_pkg::SPFFE_ST_FRAME;
      next_standby = cs_q[1] && !busy_in;
      next_active = !next_standby;
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state <= spffe_pkg::SPFFE_ST_UNARMED;
         bitcnt <= '0;
         byte_idx <= '0;
         data_cnt <= '0;
         rx_sh <= '0;
         tx_sh <= '1;
         bit_seen <= 1'b0;
         opcode <= '0;
         addr <= '0;
         pend_valid <= 1'b0;
         pend <= '0;
         spare_valid <= 1'b0;
         spare <= '0;
         rx_valid_out <= 1'b0;
         rx_out <= '0;
         miso_out <= 1'b1;
         miso_oe_out <= 1'b0;
         overrun_out <= 1'b0;
         tx_ready_out <= 1'b0;
         op_start_out <= 1'b0;
         op_refused_out <= 1'b0;
         abort_out <= 1'b0;
         op_out <= '0;
         standby_out <= 1'b1;
         active_out <= 1'b0;
      end else begin
         state <= next_state;
         bitcnt <= next_bitcnt;
         byte_idx <= next_byte_idx;
         data_cnt <= next_data_cnt;
         rx_sh <= next_rx_sh;
         tx_sh <= next_tx_sh;
         bit_seen <= next_bit_seen;
         opcode <= next_opcode;
         addr <= next_addr;
         pend_valid <= next_pend_valid;
         pend <= next_pend;
         spare_valid <= next_spare_valid;
         spare <= next_spare;
         rx_valid_out <= next_rx_valid;
         rx_out <= next_rx;
         miso_out <= next_miso;
         miso_oe_out <= next_miso_oe;
         overrun_out <= next_overrun;
         tx_ready_out <= next_tx_ready;
         op_start_out <= next_op_start;
         op_refused_out <= next_op_refused;
         abort_out <= next_abort;
         op_out <= next_op;
         standby_out <= next_standby;
         active_out <= next_active;
      end
   end

endmodule : spffe_top

// [include/spffe_pkg.sv]
// Notes on behaviour
// - output bits shift out on clock falling edges
// - input bits sampled on clock rising edges
// - select high: deselected, output floats
// - standby only when deselected and core idle
// - select low enables device, active power
// - no instruction before first select falling edge
// - reset pin high: normal operation
// - reset pin low: reset state, output floats
// - reset pin low aborts running internal cycle
// - protect pin low refuses lowest 256 pages
// - protect pin high: lowest pages unprotected
// - sixteen sectors, 256 pages, 256 bytes each
// - 4096 pages, twenty bit byte address
// - page writes take one to 256 bytes
// - page rewrite is erase then program
// - erase one page or one sector
package spffe_pkg;
   localparam int BYTE_W = 8;
   localparam int ADDR_W = 20;
   localparam int SECTORS = 16;
   localparam int PAGES_PER_SECTOR = 256;
   localparam int PAGE_BYTES = 256;
   localparam int PAGES = SECTORS * PAGES_PER_SECTOR;
   localparam int PAGE_W = 12;
   localparam int PROT_PAGES = 256;
   localparam int SYNC_W = 3;
   localparam logic [PAGE_W-1:0] PROT_LIMIT = 12'h100;
   localparam logic [8:0] MAX_DATA = 9'h100;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam logic [2:0] IDX_DATA = 3'h4;
   localparam logic [7:0] IDLE_TX = 8'hFF;

   typedef enum logic [2:0] {
      SPFFE_ST_UNARMED = 3'b001,
      SPFFE_ST_IDLE = 3'b010,
      SPFFE_ST_FRAME = 3'b100
   } spffe_state_t;

   typedef enum logic [1:0] {
      SPFFE_OP_REWRITE = 2'h0,
      SPFFE_OP_BURN = 2'h1,
      SPFFE_OP_PAGE_CLEAR = 2'h2,
      SPFFE_OP_SECTOR_CLEAR = 2'h3
   } spffe_op_kind_t;

   typedef enum logic [1:0] {
      SPFFE_TAG_OPCODE = 2'h0,
      SPFFE_TAG_ADDR = 2'h1,
      SPFFE_TAG_DATA = 2'h2
   } spffe_tag_t;

   typedef struct packed {
      logic [BYTE_W-1:0] data;
      spffe_tag_t tag;
   } spffe_rx_t;

   typedef struct packed {
      spffe_op_kind_t kind;
      logic [ADDR_W-1:0] addr;
      logic [8:0] nbytes;
   } spffe_op_t;
endpackage : spffe_pkg

// [verification/spffe_top_sva.sv]
`timescale 1ns/1ps
module spffe_top_sva (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // watched inputs
   input wire logic sclk_in,
   input wire logic cs_n_in,
   input wire logic wp_n_in,
   input wire logic hw_rst_n_in,
   input wire logic rx_ready_in,
   input wire logic busy_in,
   // watched outputs
   input wire logic miso_out,
   input wire logic miso_oe_out,
   input wire logic rx_valid_out,
   input wire spffe_pkg::spffe_rx_t rx_out,
   input wire logic op_start_out,
   input wire spffe_pkg::spffe_op_t op_out,
   input wire logic abort_out,
   input wire logic standby_out,
   input wire logic active_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // five cycles cover the two-flop pin sync plus the output register
   sequence desel_s; cs_n_in [*5]; endsequence
   sequence sel_s; !cs_n_in [*5]; endsequence
   oe_desel_a: assert property (desel_s |-> !miso_oe_out)
      else $error("output driven while deselected");
   oe_reset_a: assert property ((!hw_rst_n_in) [*5] |-> !miso_oe_out)
      else $error("output driven in pin reset");
   stby_busy_a: assert property (busy_in |=> !standby_out)
      else $error("standby while core busy");
   stby_idle_a: assert property (desel_s ##0 !$past(busy_in) |-> standby_out)
      else $error("no standby when idle");
   act_sel_a: assert property (sel_s |-> active_out && !standby_out)
      else $error("not active while selected");
   abort_pls_a: assert property (abort_out |-> !hw_rst_n_in ##1 !abort_out)
      else $error("abort pulse wrong");
   prot_low_a: assert property (op_start_out |->
      wp_n_in || op_out.addr[19:8] >= spffe_pkg::PROT_LIMIT) else $error("protected page started");
   nbytes_a: assert property (op_start_out && !op_out.kind[1] |->
      op_out.nbytes inside {[9'h001:9'h100]}) else $error("byte count out of range");
   miso_fall_a: assert property (miso_oe_out && $past(miso_oe_out, 3) && $changed(miso_out) |->
      !$past(sclk_in, 3)) else $error("output moved off a falling edge");
   rx_hold_a: assert property (rx_valid_out && !rx_ready_in |=> rx_valid_out && $stable(rx_out))
      else $error("stalled byte lost");
endmodule : spffe_top_sva

// [verification/spffe_spi_master.sv]
`timescale 1ns/1ps
module spffe_spi_master #(parameter int HP = 10) (
   // clock
   input wire logic clk_in,
   // link pins
   input wire logic miso_in,
   input wire logic miso_oe_in,
   output logic sclk_out,
   output logic cs_n_out,
   output logic mosi_out
);
   logic mode3 = 1'b0;
   initial begin
      sclk_out = 1'b0;
      cs_n_out = 1'b1;
      mosi_out = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
   endtask : tick
   task automatic open_frame(input logic m3);
      mode3 = m3;
      sclk_out <= m3;
      tick(HP);
      cs_n_out <= 1'b0;
      tick(HP);
   endtask : open_frame
   // a floating output reads as unknown so it can never match
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         sclk_out <= 1'b0;
         mosi_out <= tx[i];
         tick(HP);
         sclk_out <= 1'b1;
         rx[i] = miso_oe_in ? miso_in : 1'bx;
         tick(HP);
      end
   endtask : xfer
   // released data line shows the inverse so a stale bit is never reused
   task automatic close_frame();
      sclk_out <= mode3;
      tick(HP);
      cs_n_out <= 1'b1;
      mosi_out <= ~mosi_out;
      tick(HP);
   endtask : close_frame
endmodule : spffe_spi_master

// [verification/tb_serial_page_flash_pin_front_end.sv]
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_count++; \
   $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tb_serial_page_flash_pin_front_end;
   localparam logic [7:0] OPC [4] = '{8'h01, 8'h02, 8'h03, 8'h04};
   logic clk = 1'b0, rst_n = 1'b0, hw_rst_n = 1'b1, wp_n = 1'b1, rx_ready = 1'b1;
   logic tx_en = 1'b0, tx_valid = 1'b0, busy = 1'b0;
   logic [7:0] tx_data = 8'h00;
   logic sclk, cs_n, mosi, miso, miso_oe, rx_valid, overrun, tx_ready;
   logic op_start, op_refused, abort, standby, active;
   spffe_pkg::spffe_rx_t rx;
   spffe_pkg::spffe_op_t op;
   spffe_pkg::spffe_rx_t rxq[$];
   int err_count = 0, n_checks = 0, n_start = 0, n_ref = 0, n_abort = 0, n_ovr = 0;
   int n_rdy = 0;
   spffe_top spffe_top_inst (.clk_in(clk), .rst_n_in(rst_n), .sclk_in(sclk), .cs_n_in(cs_n),
      .mosi_in(mosi), .wp_n_in(wp_n), .hw_rst_n_in(hw_rst_n), .miso_out(miso),
      .miso_oe_out(miso_oe), .rx_valid_out(rx_valid), .rx_ready_in(rx_ready), .rx_out(rx),
      .overrun_out(overrun), .tx_enable_in(tx_en), .tx_valid_in(tx_valid),
      .tx_data_in(tx_data), .tx_ready_out(tx_ready), .busy_in(busy), .op_start_out(op_start),
      .op_out(op), .op_refused_out(op_refused), .abort_out(abort), .standby_out(standby),
      .active_out(active));
   spffe_spi_master spffe_spi_master_inst (.clk_in(clk), .miso_in(miso), .miso_oe_in(miso_oe),
      .sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi));
   initial forever #2 clk = ~clk;
   always @(posedge clk) begin
      if (rx_valid && rx_ready) rxq.push_back(rx);
      n_start += int'(op_start);
      n_ref += int'(op_refused);
      n_abort += int'(abort);
      n_ovr += int'(overrun);
      n_rdy += int'(tx_ready);
   end
   function automatic logic [7:0] byte_at(input int k, input logic [23:0] ad, input int i);
      return i == 0 ? OPC[k] : i < 4 ? ad[8*(3-i) +: 8] : 8'(8'h3C + i * 7);
   endfunction : byte_at
   task automatic run_op(input logic m3, input int k, input logic [19:0] a, input int nd,
         input logic ok);
      int s0, r0;
      logic [7:0] r;
      logic [23:0] ad;
      spffe_pkg::spffe_rx_t g;
      s0 = n_start;
      r0 = n_ref;
      ad = {4'hA, a};
      rxq.delete();
      spffe_spi_master_inst.open_frame(m3);
      for (int i = 0; i < 4 + nd; i++) spffe_spi_master_inst.xfer(byte_at(k, ad, i), r);
      spffe_spi_master_inst.close_frame();
      `CHK(n_start - s0 == 1, ok)
      `CHK(n_ref - r0 == 1, !ok)
      if (ok) `CHK(op, {k[1:0], a, nd[8:0]})
      `CHK(rxq.size(), 4 + nd)
      for (int i = 0; i < 4 + nd && rxq.size() > 0; i++) begin
         g = rxq.pop_front();
         `CHK(g, {byte_at(k, ad, i), i == 0 ? 2'h0 : i < 4 ? 2'h1 : 2'h2})
      end
   endtask : run_op
   task automatic t_ops();
      for (int k = 0; k < 4; k++) run_op(k[0], k, 20'h12345, k < 2 ? 2 * k + 1 : 0, 1'b1);
      run_op(1'b0, 0, 20'h00010, 1, 1'b1);
   endtask : t_ops
   task automatic t_protect();
      wp_n <= 1'b0;
      run_op(1'b0, 2, 20'h0FF00, 0, 1'b0);
      run_op(1'b1, 1, 20'h0FFFF, 2, 1'b0);
      run_op(1'b1, 3, 20'h10000, 0, 1'b1);
      wp_n <= 1'b1;
   endtask : t_protect
   task automatic t_tx();
      logic [7:0] r;
      int y0;
      y0 = n_rdy;
      tx_en <= 1'b1;
      tx_valid <= 1'b1;
      tx_data <= 8'hA5;
      spffe_spi_master_inst.open_frame(1'b1);
      `CHK(miso_oe, 1'b1)
      // the first byte of a frame is the opcode slot; core data starts with the second
      spffe_spi_master_inst.xfer(8'h00, r);
      spffe_spi_master_inst.xfer(8'h00, r);
      `CHK(r, 8'hA5)
      tx_valid <= 1'b0;
      spffe_spi_master_inst.xfer(8'h00, r);
      `CHK(r, spffe_pkg::IDLE_TX)
      spffe_spi_master_inst.close_frame();
      `CHK(miso_oe, 1'b0)
      `CHK(n_rdy - y0, 2)
   endtask : t_tx
   // pin reset mid-frame while busy: abort, float, then ignore until select falls again
   task automatic t_reset();
      int a0;
      logic [7:0] r;
      busy <= 1'b1;
      run_op(1'b0, 0, 20'h20000, 1, 1'b0);
      `CHK({standby, active}, 2'b01)
      spffe_spi_master_inst.open_frame(1'b0);
      a0 = n_abort;
      hw_rst_n <= 1'b0;
      for (int i = 0; i < 20 && n_abort == a0; i++) @(posedge clk);
      `CHK(n_abort - a0, 1)
      repeat (6) @(posedge clk);
      `CHK(miso_oe, 1'b0)
      hw_rst_n <= 1'b1;
      busy <= 1'b0;
      repeat (8) @(posedge clk);
      rxq.delete();
      spffe_spi_master_inst.xfer(OPC[2], r);
      `CHK(rxq.size(), 0)
      `CHK(miso_oe, 1'b0)
      spffe_spi_master_inst.close_frame();
      `CHK({standby, active}, 2'b10)
      tx_en <= 1'b0;
   endtask : t_reset
   task automatic t_stall();
      logic [7:0] r;
      rx_ready <= 1'b0;
      rxq.delete();
      spffe_spi_master_inst.open_frame(1'b0);
      for (int i = 0; i < 4; i++) spffe_spi_master_inst.xfer(8'h10 + 8'(i), r);
      spffe_spi_master_inst.close_frame();
      `CHK(n_ovr, 1)
      rx_ready <= 1'b1;
      repeat (8) @(posedge clk);
      `CHK(rxq.size(), 3)
      `CHK(rxq[0].data, 8'h10)
   endtask : t_stall
   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : report_and_stop
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      t_ops();
      t_protect();
      t_tx();
      t_reset();
      t_stall();
      report_and_stop();
   end
   initial begin
      #200000;
      err_count++;
      report_and_stop();
   end
endmodule : tb_serial_page_flash_pin_front_end
bind spffe_top spffe_top_sva spffe_top_sva_inst (.clk_in, .rst_n_in, .sclk_in, .cs_n_in,
   .wp_n_in, .hw_rst_n_in, .rx_ready_in, .busy_in, .miso_out, .miso_oe_out, .rx_valid_out,
   .rx_out, .op_start_out, .op_out, .abort_out, .standby_out, .active_out);
